// file: pkg/cal_ctrl_regs.vh
// register map, field positions and timing counts of the calibration control block
//
// Summary of operation
// RULE_01 - run-control bit one runs calibration, else reset
// RULE_02 - clearing run-control bit also resets clock dividers
// RULE_03 - software clears run bit before changing settings
// RULE_04 - software sets run bit before output interface
// RULE_05 - software stops output interface before clearing run
// RULE_06 - mode config changed only while run bit clear
// RULE_07 - config bit 3 adds background offset calibration
// RULE_08 - config bit 2 adds foreground offset calibration
// RULE_09 - config bit 1 runs background calibration continuously
// RULE_10 - start clears stored values, bit 0 selects foreground
// RULE_11 - bits 6-4 set averaging; low nibble is 0x1
// RULE_12 - status bits 4-2 show calibration phase code
// RULE_13 - status bit 1 set when background halted
// RULE_14 - no background: halted set after foreground ends
// RULE_15 - status bit 0 high after foreground done/skipped
// RULE_16 - indicator pin source chosen by two-bit select
// RULE_17 - flags held clear while run bit is zero
`ifndef CAL_CTRL_REGS_VH
`define CAL_CTRL_REGS_VH

// ----------------------------------------
// register addresses (15-bit serial address)
// ----------------------------------------
`define ADDR_RUN_CONTROL 15'h0061
`define ADDR_MODE_CONFIG 15'h0062
`define ADDR_AVG_CONFIG 15'h0068
`define ADDR_STATE_READBACK 15'h006A
`define ADDR_PIN_CONFIG 15'h006B

// ----------------------------------------
// reset values and fixed fields
// ----------------------------------------
`define RST_RUN_ENABLE 1'h1
`define RST_MODE_CONFIG 4'h1
`define RST_AVG_AMOUNT 3'h6
`define AVG_LOW_NIBBLE 4'h1
`define RST_PIN_CONFIG 3'h0

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_RUN_ENABLE 0
`define BIT_FG_RUN 0
`define BIT_BG_ENABLE 1
`define BIT_FG_OFFSET 2
`define BIT_BG_OFFSET 3
`define AVG_MSB 6
`define AVG_LSB 4
`define STAT_PHASE_MSB 4
`define STAT_PHASE_LSB 2
`define STAT_HALTED 1
`define STAT_FG_COMPLETE 0
`define PIN_SEL_MSB 2
`define PIN_SEL_LSB 1

// ----------------------------------------
// indicator pin sources
// ----------------------------------------
`define PIN_SRC_FG_COMPLETE 2'h0
`define PIN_SRC_HALTED 2'h1
`define PIN_SRC_ALARM 2'h2
`define PIN_SRC_LOW 2'h3

// ----------------------------------------
// serial frame and timing counts
// ----------------------------------------
`define FRAME_BITS 5'h18
`define CMD_BITS 5'h10
`define CLEAR_CYCLES 12'h008
`define STEP_CYCLES 12'h010

`endif

// file: rtl/cal_sequencer.v
// calibration phase sequencer: clear, foreground, offset and background steps
`timescale 1ns/1ps
module cal_sequencer (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // configuration
  input wire run_enable,
  input wire fg_run,
  input wire fg_offset_en,
  input wire bg_enable,
  input wire bg_offset_en,
  input wire [2:0] avg_amount,
  input wire hold_request,
  // state
  output reg [2:0] phase,
  output reg fg_complete,
  output reg bg_halted,
  output reg values_clear
);
`include "cal_ctrl_regs.vh"

  localparam ST_HOLD = 3'h0;
  localparam ST_CLEAR = 3'h1;
  localparam ST_FG = 3'h2;
  localparam ST_FG_OS = 3'h3;
  localparam ST_BG = 3'h4;
  localparam ST_BG_OS = 3'h5;
  localparam ST_HALT = 3'h6;
  localparam ST_DONE = 3'h7;

  reg [11:0] cnt;
  wire [2:0] fg_exit;

  // offset steps lengthen with averaging depth
  function [11:0] step_len;
    input is_offset;
    input [2:0] avg;
    begin
      step_len = is_offset ? (`STEP_CYCLES << avg) : `STEP_CYCLES;
    end
  endfunction

  assign fg_exit = bg_enable ? ST_BG : ST_DONE;

  always @(posedge clk) begin
    // RULE_01 RULE_17 hold in reset
    if (sys_rst || !run_enable) begin
      phase <= ST_HOLD;
      cnt <= 12'h000;
      fg_complete <= 1'b0;
      bg_halted <= 1'b0;
      values_clear <= 1'b0;
    end else begin
      if (cnt != 12'h000)
        cnt <= cnt - 12'h001;
      case (phase)
        ST_HOLD: begin
          // RULE_10 clear stored values
          phase <= ST_CLEAR;
          cnt <= `CLEAR_CYCLES;
          values_clear <= 1'b1;
        end
        ST_CLEAR: begin
          if (cnt == 12'h000) begin
            values_clear <= 1'b0;
            // RULE_10 foreground run or skip
            if (fg_run) begin
              phase <= ST_FG;
              cnt <= step_len(1'b0, avg_amount);
            end else begin
              // RULE_15 RULE_14 skipped foreground
              phase <= fg_exit;
              fg_complete <= 1'b1;
              bg_halted <= ~bg_enable;
              cnt <= step_len(1'b0, avg_amount);
            end
          end
        end
        ST_FG: begin
          if (cnt == 12'h000) begin
            // RULE_08 foreground offset step
            if (fg_offset_en) begin
              phase <= ST_FG_OS;
              cnt <= step_len(1'b1, avg_amount);
            end else begin
              phase <= fg_exit;
              fg_complete <= 1'b1;
              bg_halted <= ~bg_enable;
              cnt <= step_len(1'b0, avg_amount);
            end
          end
        end
        ST_FG_OS: begin
          if (cnt == 12'h000) begin
            // RULE_15 RULE_14 foreground finished
            phase <= fg_exit;
            fg_complete <= 1'b1;
            bg_halted <= ~bg_enable;
            cnt <= step_len(1'b0, avg_amount);
          end
        end
        ST_BG: begin
          // RULE_09 continuous background loop
          if (cnt == 12'h000) begin
            if (hold_request) begin
              phase <= ST_HALT;
              bg_halted <= 1'b1;
            end else if (bg_offset_en) begin
              // RULE_07 background offset step
              phase <= ST_BG_OS;
              cnt <= step_len(1'b1, avg_amount);
            end else begin
              cnt <= step_len(1'b0, avg_amount);
            end
          end
        end
        ST_BG_OS: begin
          if (cnt == 12'h000) begin
            // RULE_13 halt at phase boundary
            if (hold_request) begin
              phase <= ST_HALT;
              bg_halted <= 1'b1;
            end else begin
              phase <= ST_BG;
              cnt <= step_len(1'b0, avg_amount);
            end
          end
        end
        ST_HALT: begin
          // RULE_13 resume clears halted
          if (!hold_request) begin
            phase <= ST_BG;
            bg_halted <= 1'b0;
            cnt <= step_len(1'b0, avg_amount);
          end
        end
        ST_DONE: begin
          phase <= ST_DONE;
        end
        default: begin
          phase <= ST_HOLD;
        end
      endcase
    end
  end

endmodule // cal_sequencer

// file: rtl/adc_calibration_control.v
// calibration control: serial register port, configuration, status and indicator pin
`timescale 1ns/1ps
module adc_calibration_control (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // serial register port pins
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_sdi,
  output reg spi_sdo,
  output reg spi_sdo_oe,
  // pins into the block
  input wire cal_hold_request,
  input wire alarm,
  // indicator pin
  output reg calibration_indicator_pin,
  // controls to the converter core
  output reg cal_core_rst,
  output reg divider_rst,
  output reg foreground_cal_run,
  output reg foreground_offset_cal_enable,
  output reg background_cal_enable,
  output reg background_offset_cal_enable,
  output reg [2:0] offset_averaging_amount,
  output reg stored_values_clear
);
`include "cal_ctrl_regs.vh"

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg sclk_s1;
  reg sclk_s2;
  reg sclk_s3;
  reg cs_n_s1;
  reg cs_n_s2;
  reg sdi_s1;
  reg sdi_s2;
  reg hold_s1;
  reg hold_s2;
  reg alarm_s1;
  reg alarm_s2;

  always @(posedge clk) begin
    if (sys_rst) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      cs_n_s1 <= 1'b1;
      cs_n_s2 <= 1'b1;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
      hold_s1 <= 1'b0;
      hold_s2 <= 1'b0;
      alarm_s1 <= 1'b0;
      alarm_s2 <= 1'b0;
    end else begin
      sclk_s1 <= spi_sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_n_s1 <= spi_cs_n;
      cs_n_s2 <= cs_n_s1;
      sdi_s1 <= spi_sdi;
      sdi_s2 <= sdi_s1;
      hold_s1 <= cal_hold_request;
      hold_s2 <= hold_s1;
      alarm_s1 <= alarm;
      alarm_s2 <= alarm_s1;
    end
  end

  wire sclk_rise;
  wire sclk_fall;
  wire frame_active;

  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign sclk_fall = ~sclk_s2 & sclk_s3;
  assign frame_active = ~cs_n_s2;

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg run_enable;
  reg [3:0] mode_config;
  reg [2:0] avg_amount;
  reg [2:0] pin_config;

  wire [2:0] phase;
  wire fg_complete;
  wire bg_halted;
  wire values_clear;

  // ----------------------------------------
  // serial frame shifter
  // ----------------------------------------
  // frame: read flag, 15-bit address, 8 data bits, msb first; one register per frame
  reg [4:0] bit_cnt;
  reg [22:0] shift_in;
  reg [7:0] shift_out;
  reg is_read;
  reg [14:0] addr_q;
  reg write_en;
  reg [7:0] write_data;
  reg [7:0] read_data;
  wire [15:0] cmd_word;

  assign cmd_word = {shift_in[14:0], sdi_s2};

  always @* begin
    case (cmd_word[14:0])
      `ADDR_RUN_CONTROL: read_data = {7'h00, run_enable};
      `ADDR_MODE_CONFIG: read_data = {4'h0, mode_config};
      // RULE_11 low nibble reads fixed
      `ADDR_AVG_CONFIG: read_data = {1'b0, avg_amount, `AVG_LOW_NIBBLE};
      // RULE_12 phase code readback
      `ADDR_STATE_READBACK: read_data = {3'h0, phase, bg_halted, fg_complete};
      `ADDR_PIN_CONFIG: read_data = {5'h00, pin_config};
      default: read_data = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      bit_cnt <= 5'h00;
      shift_in <= 23'h000000;
      shift_out <= 8'h00;
      is_read <= 1'b0;
      addr_q <= 15'h0000;
      write_en <= 1'b0;
      write_data <= 8'h00;
      spi_sdo <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else begin
      write_en <= 1'b0;
      if (!frame_active) begin
        bit_cnt <= 5'h00;
        is_read <= 1'b0;
        spi_sdo_oe <= 1'b0;
        spi_sdo <= 1'b0;
      end else begin
        if (sclk_rise && bit_cnt < `FRAME_BITS) begin
          shift_in <= {shift_in[21:0], sdi_s2};
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == `CMD_BITS - 5'h01) begin
            addr_q <= cmd_word[14:0];
            is_read <= cmd_word[15];
            shift_out <= read_data;
            spi_sdo_oe <= cmd_word[15];
          end
          if (bit_cnt == `FRAME_BITS - 5'h01 && !is_read) begin
            write_en <= 1'b1;
            write_data <= {shift_in[6:0], sdi_s2};
          end
        end
        if (sclk_fall && is_read && bit_cnt >= `CMD_BITS && bit_cnt < `FRAME_BITS) begin
          spi_sdo <= shift_out[7];
          shift_out <= {shift_out[6:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // mode bits feed the sequencer directly; software keeps them still while running
  always @(posedge clk) begin
    if (sys_rst) begin
      run_enable <= `RST_RUN_ENABLE;
      mode_config <= `RST_MODE_CONFIG;
      avg_amount <= `RST_AVG_AMOUNT;
      pin_config <= `RST_PIN_CONFIG;
    end else if (write_en) begin
      case (addr_q)
        // RULE_01 run bit write
        `ADDR_RUN_CONTROL: run_enable <= write_data[`BIT_RUN_ENABLE];
        `ADDR_MODE_CONFIG: mode_config <= write_data[3:0];
        // RULE_11 averaging field write
        `ADDR_AVG_CONFIG: avg_amount <= write_data[`AVG_MSB:`AVG_LSB];
        `ADDR_PIN_CONFIG: pin_config <= write_data[2:0];
        default: pin_config <= pin_config;
      endcase
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  cal_sequencer u_seq (
    .clk(clk),
    .sys_rst(sys_rst),
    .run_enable(run_enable),
    .fg_run(mode_config[`BIT_FG_RUN]),
    .fg_offset_en(mode_config[`BIT_FG_OFFSET]),
    .bg_enable(mode_config[`BIT_BG_ENABLE]),
    .bg_offset_en(mode_config[`BIT_BG_OFFSET]),
    .avg_amount(avg_amount),
    .hold_request(hold_s2),
    .phase(phase),
    .fg_complete(fg_complete),
    .bg_halted(bg_halted),
    .values_clear(values_clear)
  );

  // ----------------------------------------
  // outputs to core and indicator pin
  // ----------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      cal_core_rst <= 1'b1;
      divider_rst <= 1'b1;
      foreground_cal_run <= 1'b0;
      foreground_offset_cal_enable <= 1'b0;
      background_cal_enable <= 1'b0;
      background_offset_cal_enable <= 1'b0;
      offset_averaging_amount <= `RST_AVG_AMOUNT;
      stored_values_clear <= 1'b0;
      calibration_indicator_pin <= 1'b0;
    end else begin
      // RULE_01 core held in reset
      cal_core_rst <= ~run_enable;
      // RULE_02 dividers reset too
      divider_rst <= ~run_enable;
      foreground_cal_run <= mode_config[`BIT_FG_RUN];
      // RULE_08 requires foreground
      foreground_offset_cal_enable <= mode_config[`BIT_FG_OFFSET] & mode_config[`BIT_FG_RUN];
      // RULE_09 background enable
      background_cal_enable <= mode_config[`BIT_BG_ENABLE];
      // RULE_07 requires background
      background_offset_cal_enable <= mode_config[`BIT_BG_OFFSET] & mode_config[`BIT_BG_ENABLE];
      offset_averaging_amount <= avg_amount;
      stored_values_clear <= values_clear;
      // RULE_16 indicator source select
      case (pin_config[`PIN_SEL_MSB:`PIN_SEL_LSB])
        `PIN_SRC_FG_COMPLETE: calibration_indicator_pin <= fg_complete;
        `PIN_SRC_HALTED: calibration_indicator_pin <= bg_halted;
        `PIN_SRC_ALARM: calibration_indicator_pin <= alarm_s2;
        default: calibration_indicator_pin <= 1'b0;
      endcase
    end
  end

endmodule // adc_calibration_control

// file: sim/adc_calibration_control_asserts.sv
// port assertions for the calibration control block
`timescale 1ns/1ps
module adc_calibration_control_asserts (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // core controls
  input wire cal_core_rst,
  input wire divider_rst,
  input wire foreground_cal_run,
  input wire foreground_offset_cal_enable,
  input wire background_cal_enable,
  input wire background_offset_cal_enable,
  input wire [2:0] offset_averaging_amount,
  input wire stored_values_clear
);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence clear_window;
    stored_values_clear [*8] ##1 !stored_values_clear;
  endsequence
  sequence run_released;
    $fell(cal_core_rst);
  endsequence

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_div_follows_core: assert property (@(posedge clk) disable iff (sys_rst)
    divider_rst == cal_core_rst) else $error("divider reset differs from core reset");
  a_rst_holds_core: assert property (@(posedge clk)
    sys_rst |=> cal_core_rst && divider_rst) else $error("core not held in reset");
  a_avg_reset_value: assert property (@(posedge clk)
    sys_rst |=> offset_averaging_amount == 3'h6) else $error("averaging reset value wrong");
  a_fg_offset_gate: assert property (@(posedge clk) disable iff (sys_rst)
    foreground_offset_cal_enable |-> foreground_cal_run) else $error("fg offset without fg");
  a_bg_offset_gate: assert property (@(posedge clk) disable iff (sys_rst)
    background_offset_cal_enable |-> background_cal_enable) else $error("bg offset without bg");
  // an aborted run may cut the clear short, so the core reset disables it
  a_clear_nine_long: assert property (@(posedge clk) disable iff (sys_rst || cal_core_rst)
    $rose(stored_values_clear) |=> clear_window) else $error("clear pulse length wrong");
  a_clear_at_start: assert property (@(posedge clk) disable iff (sys_rst)
    run_released |-> ##[0:3] stored_values_clear) else $error("no clear at calibration start");
  a_clear_in_run: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(stored_values_clear) |-> !cal_core_rst) else $error("clear while held in reset");
endmodule // adc_calibration_control_asserts

// file: sim/adc_calibration_control_bench.sv
// self-checking bench for the calibration control block
`timescale 1ns/1ps
`include "cal_ctrl_regs.vh"
module adc_calibration_control_bench;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg sclk = 1'b0;
  reg cs_n = 1'b1;
  reg sdi = 1'b0;
  reg hold = 1'b0;
  reg alarm = 1'b0;
  wire sdo, sdo_oe, pin, core_rst, div_rst, fg_run, fg_os, bg_en, bg_os, clr;
  wire [2:0] avg;
  integer fail_count = 0;
  integer n_tests = 0;
  reg oe_mid = 1'b0;

  adc_calibration_control uut (
    .clk(clk), .sys_rst(sys_rst),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe),
    .cal_hold_request(hold), .alarm(alarm), .calibration_indicator_pin(pin),
    .cal_core_rst(core_rst), .divider_rst(div_rst), .foreground_cal_run(fg_run),
    .foreground_offset_cal_enable(fg_os), .background_cal_enable(bg_en),
    .background_offset_cal_enable(bg_os), .offset_averaging_amount(avg),
    .stored_values_clear(clr)
  );

  initial forever #4 clk = ~clk;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // sclk phases of 8 clocks leave room for the pin synchronisers
  task xfer(input rw, input [14:0] a, input [7:0] d, output [7:0] q);
    reg [23:0] f;
    integer k;
    begin
      f = {rw, a, d};
      q = 8'h00;
      cs_n = 1'b0;
      for (k = 23; k >= 0; k = k - 1) begin
        sdi = f[k];
        repeat (8) @(negedge clk);
        if (k < 8) q[k] = sdo;
        if (k == 7) oe_mid = sdo_oe;
        sclk = 1'b1;
        repeat (8) @(negedge clk);
        sclk = 1'b0;
      end
      repeat (8) @(negedge clk);
      cs_n = 1'b1;
      repeat (8) @(negedge clk);
    end
  endtask

  task wr(input [14:0] a, input [7:0] d);
    reg [7:0] q;
    begin
      xfer(1'b0, a, d, q);
      chk(oe_mid, 8'h00);
    end
  endtask

  task rd(input [14:0] a, input [7:0] m, input [7:0] e);
    reg [7:0] q;
    begin
      xfer(1'b1, a, 8'h00, q);
      chk(q & m, e);
      chk(oe_mid, 8'h01);
      chk(sdo_oe, 8'h00);
    end
  endtask

  task end_sim;
    begin
      if (fail_count == 0 && n_tests > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    fail_count = fail_count + 1;
    end_sim;
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    rd(`ADDR_RUN_CONTROL, 8'hFF, 8'h01);
    rd(`ADDR_MODE_CONFIG, 8'hFF, 8'h01);
    rd(`ADDR_AVG_CONFIG, 8'hFF, 8'h61);
    rd(15'h0070, 8'hFF, 8'h00);
    rd(`ADDR_STATE_READBACK, 8'hFF, 8'h1F);
    chk(pin, 8'h01);
    chk({fg_run, fg_os, bg_en, bg_os}, 8'h08);
    chk(avg, 8'h06);
    chk(core_rst, 8'h00);
    wr(`ADDR_STATE_READBACK, 8'h00);
    rd(`ADDR_STATE_READBACK, 8'hFF, 8'h1F);
    wr(`ADDR_RUN_CONTROL, 8'h00);
    chk({core_rst, div_rst}, 8'h03);
    rd(`ADDR_STATE_READBACK, 8'hFF, 8'h00);
    chk(pin, 8'h00);
    // offset requests without their companion stay off
    wr(`ADDR_MODE_CONFIG, 8'h0C);
    chk({fg_run, fg_os, bg_en, bg_os}, 8'h00);
    wr(`ADDR_RUN_CONTROL, 8'h01);
    rd(`ADDR_STATE_READBACK, 8'hFF, 8'h1F);
    wr(`ADDR_RUN_CONTROL, 8'h00);
    wr(`ADDR_MODE_CONFIG, 8'h0F);
    wr(`ADDR_AVG_CONFIG, 8'h71);
    rd(`ADDR_MODE_CONFIG, 8'hFF, 8'h0F);
    rd(`ADDR_AVG_CONFIG, 8'hFF, 8'h71);
    chk({fg_run, fg_os, bg_en, bg_os}, 8'h0F);
    chk(avg, 8'h07);
    wr(`ADDR_RUN_CONTROL, 8'h01);
    repeat (2400) @(negedge clk);
    rd(`ADDR_STATE_READBACK, 8'h03, 8'h01);
    hold = 1'b1;
    repeat (2600) @(negedge clk);
    rd(`ADDR_STATE_READBACK, 8'hFF, 8'h1B);
    wr(`ADDR_PIN_CONFIG, 8'h02);
    chk(pin, 8'h01);
    hold = 1'b0;
    repeat (40) @(negedge clk);
    rd(`ADDR_STATE_READBACK, 8'h03, 8'h01);
    chk(pin, 8'h00);
    wr(`ADDR_PIN_CONFIG, 8'h04);
    alarm = 1'b1;
    repeat (8) @(negedge clk);
    chk(pin, 8'h01);
    alarm = 1'b0;
    repeat (8) @(negedge clk);
    chk(pin, 8'h00);
    wr(`ADDR_PIN_CONFIG, 8'h06);
    alarm = 1'b1;
    repeat (8) @(negedge clk);
    chk(pin, 8'h00);
    end_sim;
  end
endmodule // adc_calibration_control_bench

bind adc_calibration_control adc_calibration_control_asserts chk_i (
  .clk(clk), .sys_rst(sys_rst), .cal_core_rst(cal_core_rst), .divider_rst(divider_rst),
  .foreground_cal_run(foreground_cal_run),
  .foreground_offset_cal_enable(foreground_offset_cal_enable),
  .background_cal_enable(background_cal_enable),
  .background_offset_cal_enable(background_offset_cal_enable),
  .offset_averaging_amount(offset_averaging_amount), .stored_values_clear(stored_values_clear)
);
